// ---- src/obs_consts.vh ----
// Constants for the observe-only boundary-scan port.
`ifndef OBS_CONSTS_VH
`define OBS_CONSTS_VH
`define OBS_ST_RESET    4'h0
`define OBS_ST_IDLE     4'h1
`define OBS_ST_SEL_DR   4'h2
`define OBS_ST_CAP_DR   4'h3
`define OBS_ST_SH_DR    4'h4
`define OBS_ST_EX1_DR   4'h5
`define OBS_ST_PAU_DR   4'h6
`define OBS_ST_EX2_DR   4'h7
`define OBS_ST_UPD_DR   4'h8
`define OBS_ST_SEL_IR   4'h9
`define OBS_ST_CAP_IR   4'hA
`define OBS_ST_SH_IR    4'hB
`define OBS_ST_EX1_IR   4'hC
`define OBS_ST_PAU_IR   4'hD
`define OBS_ST_EX2_IR   4'hE
`define OBS_ST_UPD_IR   4'hF
`define OBS_IR_W        4
`define OBS_IR_EXTEST   4'h0
`define OBS_IR_SAMPLE   4'h1
`define OBS_IR_IDCODE   4'h2
`define OBS_IR_BYPASS   4'hF
`define OBS_IR_CAPTURE  4'h1
`define OBS_ID_W        32
`define OBS_ID_VALUE    32'h00000001
`define OBS_BS_W        8
`endif

// ---- src/obs_shift_reg.v ----
// Capture-and-shift register used for the scan chain and identification word.
`timescale 1ns/1ps
module obs_shift_reg #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         tck_rise,
  input  wire         capture,
  input  wire         shift,
  input  wire         ser_in,
  input  wire [W-1:0] par_in,
  output reg  [W-1:0] data
);
  // Capture loads the parallel word; shift moves toward bit 0, new bit at the top.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data <= {W{1'b0}};
    end else if (tck_rise && capture) begin
      data <= par_in;
    end else if (tck_rise && shift) begin
      data <= {ser_in, data[W-1:1]};
    end
  end
endmodule // obs_shift_reg

// ---- src/obs_tap.v ----
// Observe-only boundary-scan test access port, sampled on the block clock.
// Behaviour notes for whoever picks this block up next.
//
// The test clock is not used as a clock here.
// It is treated as a slow pin and sampled by the block clock through two flip-flops.
// A third flip-flop holds the previous synchronised level, so rises and falls are
// seen as one-cycle pulses of the block clock.
// This keeps the whole block in one clock domain at the cost of a few cycles of lag.
// Mode select and scan in pass the same two flip-flops as the test clock.
// Because the lag is equal, the value seen at a detected rise is the pin level at
// that rise, provided the tester holds it for a few block cycles around the edge.
// The test clock must stay high and low for at least three block cycles each.
// A shorter phase could be lost between samples and an edge would go unseen.
//
// There is no test reset pin.
// The state machine reaches its reset state after five rising test clocks with
// mode select high, whatever state it started in.
// The logic reset from the controller also forces that state directly.
// Entering the reset state puts the identification word back in the instruction
// register, so a tester can read it without loading an instruction first.
//
// Scan out is registered and changes only after a detected falling edge.
// The tester reads it before the next rise, which gives half a test clock of margin.
// The output enable follows the same edge and is high only while shifting.
// Outside shifting the pin still takes a new bit at each falling edge, with the enable low.
//
// The boundary chain is observe only.
// It captures the synchronised pin levels and shifts them out, lowest pin first.
// It has no update stage, so no instruction can reach a functional pin.
// The drive-test and sample codes therefore behave the same way in this block.
// That trade keeps the functional pins free of any test path.
//
// Codes that select no register fall back to the one-bit bypass stage.
// The bypass bit is cleared on capture, so the first bit out is always zero.
//
// All widths and codes live in the constants header.
// The identification value there is arbitrary and carries no maker code.
// Changing the chain width means changing the observed pin port to match.
//
// Limitations.
// The block cannot follow a test clock faster than about a sixth of its own clock.
// Pins are sampled only at capture; a glitch between captures is never seen.
// The pause states hold the chain unchanged for as long as the tester wishes.
`include "obs_consts.vh"
`timescale 1ns/1ps
module obs_tap (
  input  wire                 ref_clk,
  input  wire                 rst,
  input  wire                 tck,
  input  wire                 tms,
  input  wire                 tdi,
  input  wire [`OBS_BS_W-1:0] pin_obs,
  output reg                  tdo,
  output reg                  tdo_oe,
  output reg  [3:0]           tap_state
);
  // Two-flop synchronisers; the first stage feeds only the second.
  reg [1:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg [`OBS_BS_W-1:0] pin_m;
  reg [`OBS_BS_W-1:0] pin_s;
  reg       tck_d;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tck_s <= 2'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h0;
      tck_d <= 1'b0;
      pin_m <= {`OBS_BS_W{1'b0}};
      pin_s <= {`OBS_BS_W{1'b0}};
    end else begin
      tck_s <= {tck_s[0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      tck_d <= tck_s[1];
      pin_m <= pin_obs;
      pin_s <= pin_m;
    end
  end

  // Edges of the test clock; tms and tdi lag tck by the same two flops.
  wire tck_rise = tck_s[1] & ~tck_d;
  wire tck_fall = ~tck_s[1] & tck_d;
  wire tms_q    = tms_s[1];
  wire tdi_q    = tdi_s[1];

  // Standard sixteen-state machine; five high tms clocks always reach reset.
  reg [3:0] next_state;
  always @* begin
    next_state = tap_state;
    case (tap_state)
      `OBS_ST_RESET:  next_state = tms_q ? `OBS_ST_RESET  : `OBS_ST_IDLE;
      `OBS_ST_IDLE:   next_state = tms_q ? `OBS_ST_SEL_DR : `OBS_ST_IDLE;
      `OBS_ST_SEL_DR: next_state = tms_q ? `OBS_ST_SEL_IR : `OBS_ST_CAP_DR;
      `OBS_ST_CAP_DR: next_state = tms_q ? `OBS_ST_EX1_DR : `OBS_ST_SH_DR;
      `OBS_ST_SH_DR:  next_state = tms_q ? `OBS_ST_EX1_DR : `OBS_ST_SH_DR;
      `OBS_ST_EX1_DR: next_state = tms_q ? `OBS_ST_UPD_DR : `OBS_ST_PAU_DR;
      `OBS_ST_PAU_DR: next_state = tms_q ? `OBS_ST_EX2_DR : `OBS_ST_PAU_DR;
      `OBS_ST_EX2_DR: next_state = tms_q ? `OBS_ST_UPD_DR : `OBS_ST_SH_DR;
      `OBS_ST_UPD_DR: next_state = tms_q ? `OBS_ST_SEL_DR : `OBS_ST_IDLE;
      `OBS_ST_SEL_IR: next_state = tms_q ? `OBS_ST_RESET  : `OBS_ST_CAP_IR;
      `OBS_ST_CAP_IR: next_state = tms_q ? `OBS_ST_EX1_IR : `OBS_ST_SH_IR;
      `OBS_ST_SH_IR:  next_state = tms_q ? `OBS_ST_EX1_IR : `OBS_ST_SH_IR;
      `OBS_ST_EX1_IR: next_state = tms_q ? `OBS_ST_UPD_IR : `OBS_ST_PAU_IR;
      `OBS_ST_PAU_IR: next_state = tms_q ? `OBS_ST_EX2_IR : `OBS_ST_PAU_IR;
      `OBS_ST_EX2_IR: next_state = tms_q ? `OBS_ST_UPD_IR : `OBS_ST_SH_IR;
      `OBS_ST_UPD_IR: next_state = tms_q ? `OBS_ST_SEL_DR : `OBS_ST_IDLE;
      default:        next_state = `OBS_ST_RESET;
    endcase
  end

  // The state advances only on a test clock rising edge; no test reset pin exists.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tap_state <= `OBS_ST_RESET;
    end else if (tck_rise) begin
      tap_state <= next_state;
    end
  end

  // Instruction shift and update; reset state selects the identification word.
  reg [`OBS_IR_W-1:0] ir_sh;
  reg [`OBS_IR_W-1:0] ir;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_sh <= `OBS_IR_CAPTURE;
      ir    <= `OBS_IR_IDCODE;
    end else if (tck_rise) begin
      case (tap_state)
        `OBS_ST_RESET:  ir    <= `OBS_IR_IDCODE;
        `OBS_ST_CAP_IR: ir_sh <= `OBS_IR_CAPTURE;
        `OBS_ST_SH_IR:  ir_sh <= {tdi_q, ir_sh[`OBS_IR_W-1:1]};
        `OBS_ST_UPD_IR: ir    <= ir_sh;
        default:        ir    <= ir;
      endcase
    end
  end

  // Data register selection; unknown codes act as bypass.
  wire sel_id = (ir == `OBS_IR_IDCODE);
  wire sel_bs = (ir == `OBS_IR_SAMPLE) || (ir == `OBS_IR_EXTEST);
  wire cap_dr = (tap_state == `OBS_ST_CAP_DR);
  wire sh_dr  = (tap_state == `OBS_ST_SH_DR);

  wire [`OBS_ID_W-1:0] id_q;
  wire [`OBS_BS_W-1:0] bs_q;

  // Identification word, shifted out bit 0 first.
  obs_shift_reg #(.W(`OBS_ID_W)) u_id (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tck_rise (tck_rise),
    .capture  (cap_dr & sel_id),
    .shift    (sh_dr & sel_id),
    .ser_in   (tdi_q),
    .par_in   (`OBS_ID_VALUE),
    .data     (id_q)
  );

  // Observe-only chain: captures pins, has no update stage and no pin drive.
  obs_shift_reg #(.W(`OBS_BS_W)) u_bs (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tck_rise (tck_rise),
    .capture  (cap_dr & sel_bs),
    .shift    (sh_dr & sel_bs),
    .ser_in   (tdi_q),
    .par_in   (pin_s),
    .data     (bs_q)
  );

  // Single bypass bit, cleared on capture.
  reg byp;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byp <= 1'b0;
    end else if (tck_rise && cap_dr) begin
      byp <= 1'b0;
    end else if (tck_rise && sh_dr) begin
      byp <= tdi_q;
    end
  end

  // Output bit chosen from the register being shifted.
  wire sh_ir = (tap_state == `OBS_ST_SH_IR);
  wire out_bit = sh_ir  ? ir_sh[0] :
                 sel_id ? id_q[0]  :
                 sel_bs ? bs_q[0]  : byp;

  // Scan out changes on the falling edge so the tester samples a stable bit.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= out_bit;
      tdo_oe <= sh_ir | sh_dr;
    end
  end
endmodule // obs_tap

// ---- tb/obs_tap_asserts.sv ----
// Checker for the observe-only boundary-scan port, bound to its ports.
`include "obs_consts.vh"
`timescale 1ns/1ps
module obs_tap_asserts (
  input wire       ref_clk,
  input wire       rst,
  input wire       tck,
  input wire       tms,
  input wire       tdo,
  input wire       tdo_oe,
  input wire [3:0] tap_state
);
  // All checks run on the block clock; the logic reset silences them.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> tap_state == `OBS_ST_RESET && !tdo_oe && !tdo; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_step; $changed(tap_state) |-> $past(tck, 2) || $past(tck, 3); endproperty
  a_step: assert property (p_step) else $error("state moved without test clock");
  property p_tdo; $changed(tdo) |-> !$past(tck, 2); endproperty
  a_tdo: assert property (p_tdo) else $error("scan out moved off falling edge");
  property p_oe_up; $rose(tdo_oe) |-> tap_state inside {`OBS_ST_SH_DR, `OBS_ST_SH_IR}; endproperty
  a_oe_up: assert property (p_oe_up) else $error("scan out enabled outside shift");
  property p_oe_dn; $fell(tdo_oe) |-> tap_state inside {`OBS_ST_EX1_DR, `OBS_ST_EX1_IR}; endproperty
  a_oe_dn: assert property (p_oe_dn) else $error("scan out disabled too early");
  // Transitions are judged against mode select as it stood at the test clock rise.
  property p_rst_exit; $changed(tap_state) && $past(tap_state) == `OBS_ST_RESET
    |-> tap_state == `OBS_ST_IDLE && !$past(tms, 3); endproperty
  a_rst_exit: assert property (p_rst_exit) else $error("bad exit from reset");
  property p_sel; $changed(tap_state) && $past(tap_state) == `OBS_ST_SEL_DR
    |-> tap_state == ($past(tms, 3) ? `OBS_ST_SEL_IR : `OBS_ST_CAP_DR); endproperty
  a_sel: assert property (p_sel) else $error("bad exit from select");
  property p_sh; $changed(tap_state) && $past(tap_state) == `OBS_ST_SH_DR
    |-> tap_state == `OBS_ST_EX1_DR && $past(tms, 3); endproperty
  a_sh: assert property (p_sh) else $error("bad exit from shift");
endmodule // obs_tap_asserts
bind obs_tap obs_tap_asserts chk (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms),
  .tdo(tdo), .tdo_oe(tdo_oe), .tap_state(tap_state));

// ---- tb/obs_tester.sv ----
// Tester model driving test clock, mode select and scan input.
`timescale 1ns/1ps
module obs_tester (
  input  wire ref_clk,
  input  wire tdo,
  output reg  tck,
  output reg  tms,
  output reg  tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock of 8 block cycles; scan out is taken just before the rise.
  task step(input m, input d, output q);
    begin
      @(negedge ref_clk);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(negedge ref_clk);
      q = tdo;
      tck = 1'b1;
      repeat (3) @(negedge ref_clk);
    end
  endtask
  // Parks the test clock low, so a logic reset never releases on a high clock.
  task park;
    begin
      @(negedge ref_clk);
      tck = 1'b0;
    end
  endtask
endmodule // obs_tester

// ---- tb/obs_tap_tb.sv ----
// Self-checking bench for the observe-only boundary-scan port.
`include "obs_consts.vh"
`timescale 1ns/1ps
module obs_tap_tb;
  reg        ref_clk = 1'b0;
  reg        rst = 1'b1;
  reg  [7:0] pin_obs = 8'h00;
  wire       tck, tms, tdi, tdo, tdo_oe;
  wire [3:0] tap_state;
  integer    err_count = 0;
  integer    compares = 0;
  integer    cyc = 0;
  integer    i;
  reg        q;
  reg [31:0] got;
  `define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
    err_count = err_count + 1; $display("[ERR] %0t got %h want %h", $time, a, b); end end
  obs_tap uut (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .pin_obs(pin_obs), .tdo(tdo), .tdo_oe(tdo_oe), .tap_state(tap_state));
  obs_tester tst (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  always #25 ref_clk = ~ref_clk;
  // A hung run is cut short after far more cycles than the sequence needs.
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      if (err_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task do_rst;
    begin
      tst.park;
      rst = 1'b1;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      `CHK(tap_state, `OBS_ST_RESET)
      `CHK(tdo_oe, 1'b0)
    end
  endtask
  // Shifts n bits with mode select high on the last; scan out lands in got.
  task shift(input integer n, input [31:0] din);
    begin
      for (i = 0; i < n; i = i + 1) begin
        tst.step(i == n - 1, din[i], q);
        got[i] = q;
        `CHK(tdo_oe, 1'b1)
      end
      tst.step(1'b1, 1'b0, q);
      tst.step(1'b0, 1'b0, q);
    end
  endtask
  task t_id(input tms_rst);
    begin
      if (tms_rst) repeat (6) tst.step(1'b1, 1'b0, q);
      @(negedge ref_clk);
      `CHK(tap_state, `OBS_ST_RESET)
      for (i = 0; i < 4; i = i + 1) tst.step(i == 1, 1'b0, q);
      shift(32, 32'h0);
      `CHK(got, `OBS_ID_VALUE)
    end
  endtask
  // Loads an instruction from idle; the capture pattern comes back first.
  task t_ir(input [3:0] code);
    begin
      for (i = 0; i < 4; i = i + 1) tst.step(i < 2, 1'b0, q);
      shift(4, {28'h0, code});
      `CHK(got[3:0], `OBS_IR_CAPTURE)
    end
  endtask
  task t_dr(input [7:0] pins, input [7:0] din, input [7:0] want);
    begin
      pin_obs = pins;
      for (i = 0; i < 3; i = i + 1) tst.step(i == 0, 1'b0, q);
      pin_obs = ~pins;
      shift(8, {24'h0, din});
      `CHK(got[7:0], want)
    end
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    do_rst;
    t_id(1'b1);
    t_ir(`OBS_IR_SAMPLE);
    t_dr(8'hA5, 8'hFF, 8'hA5);
    t_ir(`OBS_IR_EXTEST);
    t_dr(8'h5A, 8'h00, 8'h5A);
    t_ir(`OBS_IR_BYPASS);
    t_dr(8'h00, 8'hC3, 8'h86);
    t_ir(`OBS_IR_BYPASS);
    do_rst;
    t_id(1'b0);
    wrap_up;
  end
endmodule // obs_tap_tb
